// ### shared/cmd_unit_defs.svh
// command unit constants: opcodes, field positions, reset values.
// assumes inclusion by bare name; definitions only.
`ifndef CMD_UNIT_DEFS_SVH
`define CMD_UNIT_DEFS_SVH

`define CAL_W 24
`define CMD_RESUME_LO 8'h00
`define CMD_SELF_BOTH 8'hf0
`define CMD_SELF_OFS 8'hf1
`define CMD_SELF_GAIN 8'hf2
`define CMD_SYS_OFS 8'hf3
`define CMD_SYS_GAIN 8'hf4
`define CMD_SYNC 8'hfc
`define CMD_STANDBY 8'hfd
`define CMD_REG_RESET 8'hfe
`define CMD_RESUME_HI 8'hff
`define ACR_RESET 8'h20
`define ACR_CLK_MASK 8'h60
`define CAL_OFS_RESET 24'h000000
`define CAL_FS_RESET 24'h400000

`endif

// ### shared/cmd_unit_pkg.sv
// types shared by the command unit: states, calibration kinds, results.
// assumes the defs header is on the include path.
`include "cmd_unit_defs.svh"
package cmd_unit_pkg;
  typedef enum logic [5:0] {
    ST_RUN = 6'b000001,
    ST_CAL = 6'b000010,
    ST_SETTLE = 6'b000100,
    ST_SYNC = 6'b001000,
    ST_SYNC_ARM = 6'b010000,
    ST_STBY = 6'b100000
  } unit_state_e;

  typedef enum logic [2:0] {
    CAL_SELF_BOTH = 3'h0,
    CAL_SELF_OFS = 3'h1,
    CAL_SELF_GAIN = 3'h2,
    CAL_SYS_OFS = 3'h3,
    CAL_SYS_GAIN = 3'h4
  } cal_kind_e;

  typedef struct packed {
    logic [`CAL_W-1:0] offset;
    logic [`CAL_W-1:0] gain;
  } cal_result_s;
endpackage

// ### core/cmd_byte_rx.sv
// serial command byte receiver, msb first, sampled on rising sclk.
// assumes sclk, cs_n and din already synchronous to clock.
`timescale 1ns/10ps
`default_nettype none
module cmd_byte_rx
(
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // serial pins
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  // received data
  output logic [7:0] byte_q,
  output logic byte_valid_q,
  output logic first_edge_q
);
  logic sclk_q;
  logic [2:0] cnt_q;
  logic [2:0] cnt_d;
  logic [7:0] sh_q;
  logic [7:0] sh_d;
  logic [7:0] byte_d;
  logic byte_valid_d;
  logic first_edge_d;
  logic rise;

  // edges with chip select high never reach the shifter
  assign rise = sclk & ~sclk_q & ~cs_n;

  always_comb
  begin
    cnt_d = cnt_q;
    sh_d = sh_q;
    byte_d = byte_q;
    byte_valid_d = 1'b0;
    first_edge_d = 1'b0;
    if (cs_n)
    begin
      cnt_d = 3'h0;
    end
    else if (rise)
    begin
      sh_d = {sh_q[6:0], din};
      first_edge_d = (cnt_q == 3'h0);
      if (cnt_q == 3'h7)
      begin
        byte_d = {sh_q[6:0], din};
        byte_valid_d = 1'b1;
        cnt_d = 3'h0;
      end
      else
      begin
        cnt_d = cnt_q + 3'h1;
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      sclk_q <= 1'b0;
      cnt_q <= 3'h0;
      sh_q <= 8'h00;
      byte_q <= 8'h00;
      byte_valid_q <= 1'b0;
      first_edge_q <= 1'b0;
    end
    else
    begin
      sclk_q <= sclk;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      byte_q <= byte_d;
      byte_valid_q <= byte_valid_d;
      first_edge_q <= first_edge_d;
    end
  end
endmodule
`default_nettype wire

// ### core/calib_sync_standby_cmd_unit.sv
// calibration, synchronisation, standby and register-reset commands.
// assumes all inputs synchronous to clock; the calibration engine and
// the conversion datapath sit outside and talk over plain ports.
// Summary of operation
// - self offset plus gain calibration updates both cal registers
// - self offset calibration updates only the offset register
// - self gain calibration updates only the full-scale register
// - system offset calibration updates the offset register
// - system gain calibration updates the full-scale register
// - data ready goes high at calibration start, low on settled data
// - sync on first master clock rise after the next byte's first sclk edge, resume or not
// - standby command enters low power until resume
// - sclk with chip select high is ignored in standby
// - resume command leaves standby
// - standby then resume sets conv_run_q and restarts continuous conversion
// - resume decodes from 00h or ffh identically
// - register reset restores the analog control register default but keeps clock divider bits
// - register reset ends continuous readout mode unless readout_enter is high in the same cycle
// - self calibrations decode from f0h, f1h, f2h
// - sync, standby, register reset decode from fch, fdh, feh
`timescale 1ns/10ps
`default_nettype none
`include "cmd_unit_defs.svh"
module calib_sync_standby_cmd_unit
  import cmd_unit_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // serial port
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  // conversion timing and datapath events
  input wire logic master_clock_in,
  input wire logic conv_done,
  input wire logic data_taken,
  // calibration engine
  input wire logic cal_done,
  input wire cal_result_s cal_result,
  // register path
  input wire logic acr_wr,
  input wire logic [7:0] acr_wdata,
  input wire logic readout_enter,
  // status and control out
  output logic data_ready_n_q,
  output logic [`CAL_W-1:0] offset_cal_reg_q,
  output logic [`CAL_W-1:0] full_scale_cal_reg_q,
  output logic cal_start_q,
  output cal_kind_e cal_kind_q,
  output logic conv_run_q,
  output logic conv_sync_q,
  output logic standby_q,
  output logic reg_reset_q,
  output logic continuous_readout_mode_q,
  output logic [7:0] analog_control_reg_q
);
  logic [7:0] rx_byte;
  logic rx_valid;
  logic rx_first;
  logic mclk_q;
  logic mclk_rise;
  logic synced_q, synced_d, resumed_q, resumed_d;
  unit_state_e state_q, state_d;
  logic data_ready_n_d, cal_start_d, run_d, sync_d, stby_d, rst_d, crm_d;
  cal_kind_e kind_d;
  logic [`CAL_W-1:0] ofs_d, fs_d;
  logic [7:0] acr_d;

  function automatic logic is_resume(input logic [7:0] b);
    is_resume = (b == `CMD_RESUME_LO) || (b == `CMD_RESUME_HI);
  endfunction

  function automatic logic is_cal(input logic [7:0] b);
    is_cal = (b >= `CMD_SELF_BOTH) && (b <= `CMD_SYS_GAIN);
  endfunction

  cmd_byte_rx u_rx
  (
    .clock(clock),
    .nrst(nrst),
    .sclk(sclk),
    .cs_n(cs_n),
    .din(din),
    .byte_q(rx_byte),
    .byte_valid_q(rx_valid),
    .first_edge_q(rx_first)
  );

  assign mclk_rise = master_clock_in & ~mclk_q;

  always_comb
  begin
    state_d = state_q;
    data_ready_n_d = data_ready_n_q;
    cal_start_d = 1'b0;
    kind_d = cal_kind_q;
    run_d = conv_run_q;
    sync_d = 1'b0;
    stby_d = standby_q;
    rst_d = 1'b0;
    crm_d = continuous_readout_mode_q;
    ofs_d = offset_cal_reg_q;
    fs_d = full_scale_cal_reg_q;
    acr_d = analog_control_reg_q;
    synced_d = synced_q;
    resumed_d = resumed_q;
    if (acr_wr)
      acr_d = acr_wdata;
    // new data beats a read in the same cycle
    if (data_taken)
      data_ready_n_d = 1'b1;
    unique case (state_q)
      ST_RUN:
      begin
        if (conv_done)
          data_ready_n_d = 1'b0;
        if (rx_valid)
        begin
          if (is_cal(rx_byte))
          begin
            state_d = ST_CAL;
            cal_start_d = 1'b1;
            kind_d = cal_kind_e'(rx_byte[2:0]);
            data_ready_n_d = 1'b1;
          end
          else if (rx_byte == `CMD_SYNC)
          begin
            state_d = ST_SYNC;
            run_d = 1'b0;
          end
          else if (rx_byte == `CMD_STANDBY)
          begin
            state_d = ST_STBY;
            stby_d = 1'b1;
            run_d = 1'b0;
          end
          else if (rx_byte == `CMD_REG_RESET)
          begin
            rst_d = 1'b1;
            acr_d = (`ACR_RESET & ~`ACR_CLK_MASK)
              | (analog_control_reg_q & `ACR_CLK_MASK);
            crm_d = 1'b0;
          end
        end
      end
      // bytes during calibration are dropped; the host must wait
      ST_CAL:
      begin
        if (cal_done)
        begin
          state_d = ST_SETTLE;
          if (cal_kind_q == CAL_SELF_BOTH || cal_kind_q == CAL_SELF_OFS
            || cal_kind_q == CAL_SYS_OFS)
            ofs_d = cal_result.offset;
          if (cal_kind_q == CAL_SELF_BOTH || cal_kind_q == CAL_SELF_GAIN
            || cal_kind_q == CAL_SYS_GAIN)
            fs_d = cal_result.gain;
        end
      end
      ST_SETTLE:
      begin
        data_ready_n_d = 1'b1;
        if (conv_done)
        begin
          data_ready_n_d = 1'b0;
          state_d = ST_RUN;
        end
      end
      ST_SYNC:
      begin
        synced_d = 1'b0;
        resumed_d = 1'b0;
        // the byte is not known yet, so arm on its first edge
        if (rx_first)
          state_d = ST_SYNC_ARM;
      end
      ST_SYNC_ARM:
      begin
        if (mclk_rise && !synced_q)
        begin
          sync_d = 1'b1;
          run_d = 1'b1;
          synced_d = 1'b1;
        end
        if (rx_valid)
        begin
          if (is_resume(rx_byte))
            resumed_d = 1'b1;
          else
          begin
            state_d = ST_SYNC;
            run_d = 1'b0;
          end
        end
        if ((synced_q || (mclk_rise && !synced_q))
          && (resumed_q || (rx_valid && is_resume(rx_byte))))
          state_d = ST_RUN;
      end
      ST_STBY:
      begin
        // cs high edges never form a byte here
        if (rx_valid && is_resume(rx_byte))
        begin
          state_d = ST_RUN;
          stby_d = 1'b0;
          run_d = 1'b1;
        end
      end
    endcase
    // a request to enter continuous readout wins over the clear
    if (readout_enter)
      crm_d = 1'b1;
  end

  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      state_q <= ST_RUN;
      mclk_q <= 1'b0;
      synced_q <= 1'b0;
      resumed_q <= 1'b0;
      data_ready_n_q <= 1'b1;
      offset_cal_reg_q <= `CAL_OFS_RESET;
      full_scale_cal_reg_q <= `CAL_FS_RESET;
      cal_start_q <= 1'b0;
      cal_kind_q <= CAL_SELF_BOTH;
      conv_run_q <= 1'b1;
      conv_sync_q <= 1'b0;
      standby_q <= 1'b0;
      reg_reset_q <= 1'b0;
      continuous_readout_mode_q <= 1'b0;
      analog_control_reg_q <= `ACR_RESET;
    end
    else
    begin
      state_q <= state_d;
      mclk_q <= master_clock_in;
      synced_q <= synced_d;
      resumed_q <= resumed_d;
      data_ready_n_q <= data_ready_n_d;
      offset_cal_reg_q <= ofs_d;
      full_scale_cal_reg_q <= fs_d;
      cal_start_q <= cal_start_d;
      cal_kind_q <= kind_d;
      conv_run_q <= run_d;
      conv_sync_q <= sync_d;
      standby_q <= stby_d;
      reg_reset_q <= rst_d;
      continuous_readout_mode_q <= crm_d;
      analog_control_reg_q <= acr_d;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  property p_cal_begin;
    state_q == ST_RUN && rx_valid && is_cal(rx_byte)
      |=> data_ready_n_q && cal_start_q && state_q == ST_CAL;
  endproperty
  a_cal_begin: assert property (p_cal_begin)
    else $error("data ready not raised at calibration start");

  property p_cal_hold;
    state_q == ST_SETTLE && !conv_done |=> data_ready_n_q;
  endproperty
  a_cal_hold: assert property (p_cal_hold)
    else $error("data ready fell before settled data");

  property p_self_both;
    state_q == ST_CAL && cal_done && cal_kind_q == CAL_SELF_BOTH
      |=> offset_cal_reg_q == $past(cal_result.offset)
      && full_scale_cal_reg_q == $past(cal_result.gain);
  endproperty
  a_self_both: assert property (p_self_both)
    else $error("combined calibration did not load both registers");

  property p_self_ofs;
    state_q == ST_CAL && cal_done && cal_kind_q == CAL_SELF_OFS
      |=> offset_cal_reg_q == $past(cal_result.offset)
      && $stable(full_scale_cal_reg_q);
  endproperty
  a_self_ofs: assert property (p_self_ofs)
    else $error("self offset calibration touched the wrong register");

  property p_self_gain;
    state_q == ST_CAL && cal_done && cal_kind_q == CAL_SELF_GAIN
      |=> full_scale_cal_reg_q == $past(cal_result.gain)
      && $stable(offset_cal_reg_q);
  endproperty
  a_self_gain: assert property (p_self_gain)
    else $error("self gain calibration touched the wrong register");

  property p_sys_ofs;
    state_q == ST_CAL && cal_done && cal_kind_q == CAL_SYS_OFS
      |=> offset_cal_reg_q == $past(cal_result.offset);
  endproperty
  a_sys_ofs: assert property (p_sys_ofs)
    else $error("system offset result not loaded");

  property p_sys_gain;
    state_q == ST_CAL && cal_done && cal_kind_q == CAL_SYS_GAIN
      |=> full_scale_cal_reg_q == $past(cal_result.gain);
  endproperty
  a_sys_gain: assert property (p_sys_gain)
    else $error("system gain result not loaded");

  property p_sync_edge;
    conv_sync_q |-> $past(mclk_rise) && $past(state_q) == ST_SYNC_ARM;
  endproperty
  a_sync_edge: assert property (p_sync_edge)
    else $error("sync pulse not on a master clock rise after arming");

  property p_wake;
    state_q == ST_STBY && rx_valid && is_resume(rx_byte)
      |=> !standby_q && conv_run_q && state_q == ST_RUN;
  endproperty
  a_wake: assert property (p_wake)
    else $error("resume did not leave standby");

  property p_stby_cs_high;
    state_q == ST_STBY && cs_n |=> standby_q [*2];
  endproperty
  a_stby_cs_high: assert property (p_stby_cs_high)
    else $error("standby left while chip select high");

  property p_reg_reset;
    state_q == ST_RUN && rx_valid && rx_byte == `CMD_REG_RESET && !acr_wr
      && !readout_enter
      |=> reg_reset_q && !continuous_readout_mode_q
      && ((analog_control_reg_q ^ $past(analog_control_reg_q))
      & `ACR_CLK_MASK) == 8'h00;
  endproperty
  a_reg_reset: assert property (p_reg_reset)
    else $error("register reset wrong on divider bits or readout mode");
endmodule
`default_nettype wire

// ### bench/host_port_model.sv
// host side of the serial command port: shifts stand-alone bytes.
// assumes the unit samples sclk on clock and detects its rising edges.
`timescale 1ns/10ps
`default_nettype none
module host_port_model
(
  // clock
  input wire logic clock,
  // serial pins
  output var logic sclk,
  output var logic cs_n,
  output var logic din
);
  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
    din = 1'b0;
  end

  // one byte, msb first; chip select spans the whole byte
  task automatic send(input logic [7:0] b);
    int i;
    @(negedge clock);
    cs_n = 1'b0;
    for (i = 7; i >= 0; i--)
    begin
      din = b[i];
      repeat (2) @(negedge clock);
      sclk = 1'b1;
      repeat (2) @(negedge clock);
      sclk = 1'b0;
    end
    repeat (2) @(negedge clock);
    // deselect with sclk idle so a standby is never disturbed
    cs_n = 1'b1;
    // released line: show the inverse so no stale bit looks valid
    din = ~din;
    repeat (2) @(negedge clock);
  endtask

  // clock activity while deselected; n even leaves sclk low
  task automatic idle_clocks(input int n);
    repeat (n)
    begin
      @(negedge clock);
      sclk = ~sclk;
      din = ~din;
    end
  endtask
endmodule
`default_nettype wire

// ### bench/calib_sync_standby_cmd_unit_tb.sv
// self-checking bench for the command unit.
// assumes the host model drives the serial pins; datapath events here.
`timescale 1ns/10ps
`default_nettype none
`include "cmd_unit_defs.svh"
module calib_sync_standby_cmd_unit_tb
  import cmd_unit_pkg::*;
;
  localparam logic [7:0] cal_ops [5] = '{`CMD_SELF_BOTH, `CMD_SELF_OFS,
    `CMD_SELF_GAIN, `CMD_SYS_OFS, `CMD_SYS_GAIN};
  localparam logic [4:0] upd_ofs = 5'b01011;
  localparam logic [4:0] upd_fs = 5'b10101;
  localparam logic [7:0] wake [2] = '{`CMD_RESUME_LO, `CMD_RESUME_HI};
  localparam logic [7:0] acr_vals [2] = '{8'hff, 8'h1f};
  logic clock = 1'b0;
  logic nrst, sclk, cs_n, din, master_clock_in;
  logic conv_done, data_taken, cal_done, acr_wr, readout_enter;
  cal_result_s cal_result;
  logic [7:0] acr_wdata, acr_q;
  logic data_ready_n_q, cal_start_q, conv_run_q, conv_sync_q;
  logic standby_q, reg_reset_q, readout_q;
  logic [`CAL_W-1:0] ofs_q, fs_q, exp_ofs, exp_fs;
  cal_kind_e kind_q, kind_seen;
  int failures = 0;
  int samples_checked = 0;
  int cal_cnt = 0;
  int sync_cnt = 0;
  int rst_cnt = 0;
  int i, n;

  always #5 clock = ~clock;

  host_port_model host_port_model_inst (.clock(clock), .sclk(sclk),
    .cs_n(cs_n), .din(din));

  calib_sync_standby_cmd_unit calib_sync_standby_cmd_unit_inst (
    .clock(clock), .nrst(nrst), .sclk(sclk), .cs_n(cs_n), .din(din),
    .master_clock_in(master_clock_in), .conv_done(conv_done),
    .data_taken(data_taken), .cal_done(cal_done),
    .cal_result(cal_result), .acr_wr(acr_wr), .acr_wdata(acr_wdata),
    .readout_enter(readout_enter), .data_ready_n_q(data_ready_n_q),
    .offset_cal_reg_q(ofs_q), .full_scale_cal_reg_q(fs_q),
    .cal_start_q(cal_start_q), .cal_kind_q(kind_q),
    .conv_run_q(conv_run_q), .conv_sync_q(conv_sync_q),
    .standby_q(standby_q), .reg_reset_q(reg_reset_q),
    .continuous_readout_mode_q(readout_q),
    .analog_control_reg_q(acr_q));

  // pulses are gone before a byte send returns, so count them here
  always @(posedge clock)
  begin
    if (cal_start_q === 1'b1)
    begin
      cal_cnt++;
      kind_seen = kind_q;
    end
    if (conv_sync_q === 1'b1)
      sync_cnt++;
    if (reg_reset_q === 1'b1)
      rst_cnt++;
  end

  task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen,
        exp);
    end
  endtask

  task automatic tick(input int c);
    repeat (c) @(negedge clock);
  endtask

  task automatic data_ready_n_cycle();
    conv_done = 1'b1;
    tick(1);
    conv_done = 1'b0;
    tick(1);
    chk(48'(data_ready_n_q), 48'h0);
    data_taken = 1'b1;
    tick(1);
    data_taken = 1'b0;
    tick(1);
    chk(48'(data_ready_n_q), 48'h1);
  endtask

  task automatic final_report();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // watchdog: a hang counts as a mismatch
  initial
  begin
    #900000;
    failures++;
    final_report();
  end

  initial
  begin
    {nrst, master_clock_in, conv_done, data_taken} = 4'h0;
    {cal_done, acr_wr, readout_enter} = 3'h0;
    acr_wdata = 8'h00;
    cal_result = '0;
    tick(12);
    nrst = 1'b1;
    tick(2);
    chk(48'(data_ready_n_q), 48'h1);
    chk(48'(ofs_q), 48'(`CAL_OFS_RESET));
    chk(48'(fs_q), 48'(`CAL_FS_RESET));
    chk(48'(acr_q), 48'(`ACR_RESET));
    chk(48'({conv_run_q, standby_q}), 48'h2);
    exp_ofs = `CAL_OFS_RESET;
    exp_fs = `CAL_FS_RESET;
    $display("test reset done");

    for (i = 0; i < 5; i++)
    begin
      cal_result.offset = 24'h0a0000 + 24'(i);
      cal_result.gain = 24'h050000 + 24'(i);
      n = cal_cnt;
      host_port_model_inst.send(cal_ops[i]);
      chk(48'(cal_cnt), 48'(n + 1));
      chk(48'(kind_seen), 48'(i));
      chk(48'(data_ready_n_q), 48'h1);
      if (i == 0)
      begin
        // a byte during calibration must not start another one
        host_port_model_inst.send(`CMD_SELF_OFS);
        chk(48'(cal_cnt), 48'(n + 1));
      end
      cal_done = 1'b1;
      tick(1);
      cal_done = 1'b0;
      tick(1);
      if (upd_ofs[i])
        exp_ofs = cal_result.offset;
      if (upd_fs[i])
        exp_fs = cal_result.gain;
      chk(48'(ofs_q), 48'(exp_ofs));
      chk(48'(fs_q), 48'(exp_fs));
      chk(48'(data_ready_n_q), 48'h1);
      data_ready_n_cycle();
    end
    $display("test calibration done");

    for (i = 0; i < 2; i++)
    begin
      n = cal_cnt;
      host_port_model_inst.send(`CMD_STANDBY);
      chk(48'({standby_q, conv_run_q}), 48'h2);
      host_port_model_inst.idle_clocks(16);
      chk(48'(standby_q), 48'h1);
      host_port_model_inst.send(`CMD_SELF_BOTH);
      chk(48'(cal_cnt), 48'(n));
      chk(48'(standby_q), 48'h1);
      host_port_model_inst.send(wake[i]);
      chk(48'({standby_q, conv_run_q}), 48'h1);
      data_ready_n_cycle();
    end
    $display("test standby done");

    n = sync_cnt;
    host_port_model_inst.send(`CMD_SYNC);
    chk(48'(conv_run_q), 48'h0);
    repeat (4)
    begin
      master_clock_in = 1'b1;
      tick(2);
      master_clock_in = 1'b0;
      tick(2);
    end
    chk(48'(sync_cnt), 48'(n));
    fork
      host_port_model_inst.send(`CMD_RESUME_LO);
      begin
        tick(10);
        chk(48'(sync_cnt), 48'(n));
        master_clock_in = 1'b1;
        tick(3);
        chk(48'(sync_cnt), 48'(n + 1));
      end
    join
    master_clock_in = 1'b0;
    chk(48'(conv_run_q), 48'h1);
    $display("test sync done");

    for (i = 0; i < 2; i++)
    begin
      acr_wr = 1'b1;
      acr_wdata = acr_vals[i];
      tick(1);
      acr_wr = 1'b0;
      readout_enter = 1'b1;
      tick(1);
      readout_enter = 1'b0;
      tick(1);
      chk(48'({readout_q, acr_q}), 48'({1'b1, acr_vals[i]}));
      conv_done = 1'b1;
      tick(1);
      conv_done = 1'b0;
      tick(1);
      chk(48'(data_ready_n_q), 48'h0);
      n = rst_cnt;
      host_port_model_inst.send(`CMD_REG_RESET);
      chk(48'(rst_cnt), 48'(n + 1));
      chk(48'(readout_q), 48'h0);
      chk(48'(acr_q), 48'((`ACR_RESET & ~`ACR_CLK_MASK) |
        (acr_vals[i] & `ACR_CLK_MASK)));
    end
    $display("test register reset done");
    final_report();
  end
endmodule
`default_nettype wire
